// ==== verilog/mcpbd_defs.vh ====
// Purpose: Constants for the host controller of the two-flash plus RAM package.
// Assumes: Single 40 MHz clock, synchronous active-low reset.
// Notes: Summary of rules follows.
`ifndef MCPBD_DEFS_VH
`define MCPBD_DEFS_VH

`define MCPBD_CLK_NS 25
`define MCPBD_T_ACC_NS 70
`define MCPBD_T_ODIS_NS 1000
`define MCPBD_SYNC_CYC 2
`define MCPBD_ACC_CYC ((`MCPBD_T_ACC_NS + `MCPBD_CLK_NS - 1) / `MCPBD_CLK_NS)
`define MCPBD_ODIS_CYC (`MCPBD_T_ODIS_NS / `MCPBD_CLK_NS)
`define MCPBD_CNT_W 4
`define MCPBD_RD_LAST 4'h4
`define MCPBD_WR_LAST 4'h2

`define MCPBD_ST_IDLE 3'h0
`define MCPBD_ST_SETUP 3'h1
`define MCPBD_ST_STROBE 3'h2
`define MCPBD_ST_HOLD 3'h3
`define MCPBD_ST_PDPROG 3'h4

`define MCPBD_OP_READ 2'h0
`define MCPBD_OP_WRITE 2'h1
`define MCPBD_OP_PDPROG 2'h2

`define MCPBD_TGT_F1 2'h0
`define MCPBD_TGT_F2 2'h1
`define MCPBD_TGT_RAM 2'h2

`define MCPBD_AW 22
`define MCPBD_DW 16
`define MCPBD_LANES_ON 2'h0
`define MCPBD_LANES_OFF 2'h3

`endif

// ==== verilog/mcpbd_sync2.v ====
// Purpose: Two-stage synchroniser for pins sampled from outside the clock domain.
// Assumes: Each bit is independent; words are only read once stable.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module mcpbd_sync2 #(
	parameter W = 1
) (
	input wire mclk_i,
	input wire rst_b_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_ff;

	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			meta_ff <= {W{1'b1}};
			q_o <= {W{1'b1}};
		end
		else
		begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule

// ==== verilog/mcpbd_host.v ====
// Purpose: Host controller driving the shared pins of the two-flash plus RAM package.
// Assumes: User port is on mclk_i; data and ready pins are asynchronous.
// Notes: One access at a time; the user port sees a ready/valid handshake.
`timescale 1ns/1ps
`include "mcpbd_defs.vh"
module mcpbd_host (
	input wire mclk_i,
	input wire rst_b_i,
	input wire cmd_valid_i,
	input wire [1:0] cmd_op_i,
	input wire [1:0] cmd_target_i,
	input wire [`MCPBD_AW-1:0] cmd_addr_i,
	input wire [`MCPBD_DW-1:0] cmd_wdata_i,
	input wire [1:0] cmd_be_i,
	input wire ram_sleep_i,
	input wire flash_one_reset_req_i,
	input wire flash_two_reset_req_i,
	input wire flash_one_unprotect_i,
	input wire flash_two_unprotect_i,
	input wire boot_guard_i,
	input wire [`MCPBD_DW-1:0] dq_i,
	input wire flash_one_ready_i,
	input wire flash_two_ready_i,
	output reg cmd_ready_o,
	output reg cmd_err_o,
	output reg rd_valid_o,
	output reg [`MCPBD_DW-1:0] rd_data_o,
	output reg ram_asleep_o,
	output reg [1:0] flash_busy_o,
	output reg flash_one_select_n_o,
	output reg flash_two_select_n_o,
	output reg ram_select_n_o,
	output reg ram_awake_o,
	output reg oe_n_o,
	output reg we_n_o,
	output reg low_byte_select_n_o,
	output reg high_byte_select_n_o,
	output reg sleep_program_n_o,
	output reg [`MCPBD_AW-1:0] addr_o,
	output reg [`MCPBD_DW-1:0] dq_o,
	output reg dq_oe_n_o,
	output reg flash_one_reset_n_o,
	output reg flash_two_reset_n_o,
	output reg flash_one_high_voltage_level_o,
	output reg flash_two_high_voltage_level_o,
	output reg boot_guard_boost_o
);
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [`MCPBD_CNT_W-1:0] cnt_ff;
	reg [`MCPBD_CNT_W-1:0] nxt_cnt;
	reg op_wr_ff;
	reg [1:0] tgt_ff;
	reg pd_done_ff;
	reg rw_seen_ff;
	reg legal;
	reg [1:0] be_ff;
	wire accept;
	wire quiet;
	wire any_reset;
	wire strobe_end;
	wire [`MCPBD_DW-1:0] dq_sync;
	wire [1:0] ready_sync;

	mcpbd_sync2 #(.W(`MCPBD_DW)) u_dq_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.d_i(dq_i),
		.q_o(dq_sync)
	);

	mcpbd_sync2 #(.W(2)) u_rdy_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.d_i({flash_two_ready_i, flash_one_ready_i}),
		.q_o(ready_sync)
	);

	assign accept = cmd_valid_i & cmd_ready_o;
	assign any_reset = ~flash_one_reset_n_o | ~flash_two_reset_n_o;
	// Reset entry and sleep pins may move only while every select is already high and no access starts.
	assign quiet = flash_one_select_n_o & flash_two_select_n_o & ram_select_n_o &
		~(accept & legal);
	assign strobe_end = (state_ff == `MCPBD_ST_STROBE) &&
		(cnt_ff == (op_wr_ff ? `MCPBD_WR_LAST : `MCPBD_RD_LAST));

	// Decide whether a command maps onto one of the permitted pin combinations.
	always @*
	begin
		legal = 1'b0;
		case (cmd_op_i)
			`MCPBD_OP_PDPROG:
				legal = ~pd_done_ff & ~rw_seen_ff & ram_awake_o & ~any_reset;
			`MCPBD_OP_READ, `MCPBD_OP_WRITE:
				case (cmd_target_i)
					`MCPBD_TGT_F1:
						legal = flash_one_reset_n_o;
					`MCPBD_TGT_F2:
						legal = flash_two_reset_n_o;
					`MCPBD_TGT_RAM:
						legal = ram_awake_o & ~any_reset &
							(cmd_op_i == `MCPBD_OP_READ || cmd_be_i != 2'h0);
					default:
						legal = 1'b0;
				endcase
			default:
				legal = 1'b0;
		endcase
	end

	always @*
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			`MCPBD_ST_IDLE:
			begin
				nxt_cnt = {`MCPBD_CNT_W{1'b0}};
				if (accept && legal)
					nxt_state = (cmd_op_i == `MCPBD_OP_PDPROG) ?
						`MCPBD_ST_PDPROG : `MCPBD_ST_SETUP;
			end
			`MCPBD_ST_SETUP:
				nxt_state = `MCPBD_ST_STROBE;
			`MCPBD_ST_STROBE:
			begin
				nxt_cnt = cnt_ff + 1'b1;
				if (strobe_end)
					nxt_state = `MCPBD_ST_HOLD;
			end
			`MCPBD_ST_HOLD:
				nxt_state = `MCPBD_ST_IDLE;
			`MCPBD_ST_PDPROG:
			begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == `MCPBD_WR_LAST)
					nxt_state = `MCPBD_ST_IDLE;
			end
			default:
				nxt_state = `MCPBD_ST_IDLE;
		endcase
	end

	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			state_ff <= `MCPBD_ST_IDLE;
			cnt_ff <= {`MCPBD_CNT_W{1'b0}};
			op_wr_ff <= 1'b0;
			tgt_ff <= `MCPBD_TGT_F1;
			pd_done_ff <= 1'b0;
			rw_seen_ff <= 1'b0;
			cmd_ready_o <= 1'b0;
			cmd_err_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= {`MCPBD_DW{1'b0}};
			ram_asleep_o <= 1'b0;
			flash_busy_o <= 2'h0;
			flash_one_select_n_o <= 1'b1;
			flash_two_select_n_o <= 1'b1;
			ram_select_n_o <= 1'b1;
			ram_awake_o <= 1'b1;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			low_byte_select_n_o <= 1'b1;
			high_byte_select_n_o <= 1'b1;
			sleep_program_n_o <= 1'b1;
			addr_o <= {`MCPBD_AW{1'b0}};
			dq_o <= {`MCPBD_DW{1'b0}};
			dq_oe_n_o <= 1'b1;
			flash_one_reset_n_o <= 1'b1;
			flash_two_reset_n_o <= 1'b1;
			flash_one_high_voltage_level_o <= 1'b0;
			flash_two_high_voltage_level_o <= 1'b0;
			boot_guard_boost_o <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cmd_ready_o <= (nxt_state == `MCPBD_ST_IDLE);
			cmd_err_o <= accept & ~legal;
			rd_valid_o <= 1'b0;
			flash_busy_o <= ~ready_sync;
			ram_asleep_o <= ~ram_awake_o;
			flash_one_high_voltage_level_o <= flash_one_unprotect_i;
			flash_two_high_voltage_level_o <= flash_two_unprotect_i;
			boot_guard_boost_o <= ~boot_guard_i;
			case (state_ff)
				`MCPBD_ST_IDLE:
				begin
					flash_one_select_n_o <= 1'b1;
					flash_two_select_n_o <= 1'b1;
					ram_select_n_o <= 1'b1;
					oe_n_o <= 1'b1;
					we_n_o <= 1'b1;
					low_byte_select_n_o <= 1'b1;
					high_byte_select_n_o <= 1'b1;
					sleep_program_n_o <= 1'b1;
					dq_oe_n_o <= 1'b1;
					// Reset entry and sleep change only between accesses, with all selects high; a held reset releases in idle once its request drops.
					flash_one_reset_n_o <= ~(flash_one_reset_req_i &
						(~flash_one_reset_n_o | (ram_awake_o & quiet)));
					flash_two_reset_n_o <= ~(flash_two_reset_req_i &
						(~flash_two_reset_n_o | (ram_awake_o & quiet)));
					if (quiet && !any_reset)
						ram_awake_o <= ~ram_sleep_i;
					if (accept && legal)
					begin
						op_wr_ff <= (cmd_op_i == `MCPBD_OP_WRITE);
						tgt_ff <= cmd_target_i;
						addr_o <= cmd_addr_i;
						dq_o <= cmd_wdata_i;
						if (cmd_op_i == `MCPBD_OP_PDPROG)
						begin
							sleep_program_n_o <= 1'b0;
							pd_done_ff <= 1'b1;
						end
						else
							rw_seen_ff <= 1'b1;
					end
				end
				`MCPBD_ST_SETUP:
				begin
					// Exactly one select goes low.
					flash_one_select_n_o <= (tgt_ff != `MCPBD_TGT_F1);
					flash_two_select_n_o <= (tgt_ff != `MCPBD_TGT_F2);
					ram_select_n_o <= (tgt_ff != `MCPBD_TGT_RAM);
					if (tgt_ff == `MCPBD_TGT_RAM && op_wr_ff)
					begin
						low_byte_select_n_o <= ~cmd_lane(1'b0);
						high_byte_select_n_o <= ~cmd_lane(1'b1);
					end
					else if (tgt_ff == `MCPBD_TGT_RAM)
					begin
						low_byte_select_n_o <= 1'b0;
						high_byte_select_n_o <= 1'b0;
					end
					dq_oe_n_o <= ~op_wr_ff;
				end
				`MCPBD_ST_STROBE:
				begin
					oe_n_o <= op_wr_ff;
					we_n_o <= ~op_wr_ff;
					if (strobe_end && !op_wr_ff)
					begin
						rd_data_o <= dq_sync;
						rd_valid_o <= 1'b1;
					end
					if (strobe_end)
					begin
						oe_n_o <= 1'b1;
						we_n_o <= 1'b1;
					end
				end
				`MCPBD_ST_HOLD:
				begin
					oe_n_o <= 1'b1;
					we_n_o <= 1'b1;
				end
				`MCPBD_ST_PDPROG:
					sleep_program_n_o <= (cnt_ff == `MCPBD_WR_LAST);
				default:
				begin
					oe_n_o <= 1'b1;
					we_n_o <= 1'b1;
				end
			endcase
		end
	end

	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
			be_ff <= `MCPBD_LANES_ON;
		else if (accept && legal)
			be_ff <= cmd_be_i;
	end

	// Byte enable bit 0 is the low lane, bit 1 the high lane.
	function cmd_lane;
		input sel;
		begin
			cmd_lane = sel ? be_ff[1] : be_ff[0];
		end
	endfunction
endmodule

// ==== bench/mcpbd_host_monitor.sv ====
// Purpose: Pin assertions for mcpbd_host.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every mcpbd_host.
`timescale 1ns/1ps
module mcpbd_host_monitor (
	input wire mclk_i,
	input wire rst_b_i,
	input wire flash_one_select_n_o,
	input wire flash_two_select_n_o,
	input wire ram_select_n_o,
	input wire ram_awake_o,
	input wire oe_n_o,
	input wire we_n_o,
	input wire low_byte_select_n_o,
	input wire high_byte_select_n_o,
	input wire sleep_program_n_o,
	input wire [21:0] addr_o,
	input wire rd_valid_o,
	input wire boot_guard_i,
	input wire boot_guard_boost_o,
	input wire flash_one_reset_n_o,
	input wire flash_two_reset_n_o
);
reg used_ff;
wire odis = !ram_select_n_o && ram_awake_o && oe_n_o && we_n_o;
wire idle = flash_one_select_n_o && flash_two_select_n_o && ram_select_n_o;
always @(posedge mclk_i)
	if (!rst_b_i)
		used_ff <= 1'b0;
	else if (!oe_n_o || !we_n_o || !sleep_program_n_o)
		used_ff <= 1'b1;
default clocking @(posedge mclk_i); endclocking
default disable iff (!rst_b_i);
sequence rd_burst;
	(!oe_n_o && we_n_o) [*4] ##1 (oe_n_o && rd_valid_o);
endsequence
sequence wr_pulse;
	(!we_n_o && oe_n_o) [*2] ##1 we_n_o;
endsequence
chk_one_select: assert property ($countones({!flash_one_select_n_o,
	!flash_two_select_n_o, !ram_select_n_o && ram_awake_o}) <= 1)
	else $error("two parts selected");
chk_odis_bound: assert property (odis |-> ##[1:40] !odis)
	else $error("output disable too long");
chk_read_lanes: assert property (!ram_select_n_o && !oe_n_o |->
	!(low_byte_select_n_o && high_byte_select_n_o))
	else $error("read with no lane");
chk_sleep_entry: assert property ($fell(ram_awake_o) |-> idle && $past(idle))
	else $error("sleep entered while busy");
chk_prog_idle: assert property (!sleep_program_n_o |-> idle && ram_awake_o)
	else $error("program outside standby");
chk_prog_once: assert property ($fell(sleep_program_n_o) |-> !used_ff)
	else $error("program repeated");
chk_addr_hold: assert property (!oe_n_o || !we_n_o |-> $stable(addr_o))
	else $error("address moved in strobe");
chk_read_answer: assert property ($fell(oe_n_o) |-> rd_burst)
	else $error("bad read strobe");
chk_guard_follow: assert property (1 |=> boot_guard_boost_o != $past(boot_guard_i))
	else $error("guard pin wrong");
chk_write_pulse: assert property ($fell(we_n_o) |-> wr_pulse)
	else $error("bad write strobe");
chk_reset_quiet: assert property (!flash_one_reset_n_o || !flash_two_reset_n_o |->
	ram_select_n_o || !ram_awake_o)
	else $error("RAM selected in flash reset");
endmodule
bind mcpbd_host mcpbd_host_monitor mon_u (.*);

// ==== bench/mcpbd_device.sv ====
// Purpose: Model of the two-flash plus RAM package.
// Assumes: Sixteen words per die; flash writes store at once.
// Notes: Released data lines toggle every cycle.
`timescale 1ns/1ps
module mcpbd_device (
	input wire mclk_i,
	input wire flash_one_select_n_o,
	input wire flash_two_select_n_o,
	input wire ram_select_n_o,
	input wire ram_awake_o,
	input wire oe_n_o,
	input wire we_n_o,
	input wire low_byte_select_n_o,
	input wire high_byte_select_n_o,
	input wire sleep_program_n_o,
	input wire [21:0] addr_o,
	input wire [15:0] dq_o,
	input wire dq_oe_n_o,
	input wire flash_one_reset_n_o,
	input wire flash_two_reset_n_o,
	input wire boot_guard_boost_o,
	output wire [15:0] dq_i,
	output wire flash_one_ready_i,
	output wire flash_two_ready_i
);
reg [15:0] mem [0:47];
reg [15:0] last_ff = 16'h0000;
reg [1:0] key_ff = 2'h0;
integer k;
wire ram_on = !ram_select_n_o && ram_awake_o;
wire fl_on = !flash_one_select_n_o && flash_one_reset_n_o
	|| !flash_two_select_n_o && flash_two_reset_n_o;
wire [5:0] ix = {ram_on ? 2'h2 : {1'b0, flash_one_select_n_o}, addr_o[3:0]};
wire lane = !(low_byte_select_n_o && high_byte_select_n_o);
wire rd = !oe_n_o && (fl_on || ram_on && lane);
wire boot = addr_o[21:13] == 9'h000 || &addr_o[21:13];
assign dq_i = !dq_oe_n_o ? dq_o : rd ? mem[ix] : ~last_ff;
assign flash_one_ready_i = flash_one_reset_n_o;
assign flash_two_ready_i = flash_two_reset_n_o;
always @(posedge mclk_i)
	last_ff <= dq_i;
// The key is taken as the program pulse ends, when the address has surely settled.
always @(posedge sleep_program_n_o)
	key_ff <= addr_o[1:0];
// Key zero is full sleep, which keeps nothing.
always @(posedge ram_awake_o)
	if (key_ff == 2'h0)
		for (k = 32; k < 48; k = k + 1)
			mem[k] = ~mem[k];
always @(posedge we_n_o)
	if (ram_on)
	begin
		if (!low_byte_select_n_o)
			mem[ix][7:0] = dq_o[7:0];
		if (!high_byte_select_n_o)
			mem[ix][15:8] = dq_o[15:8];
	end
	else if (fl_on && !(boot && !boot_guard_boost_o))
		mem[ix] = dq_o;
endmodule

// ==== bench/mcpbd_host_bench.sv ====
// Purpose: Self-checking bench for mcpbd_host.
// Assumes: Device model answers at once.
// Notes: Seeded RAM traffic plus refusals.
`timescale 1ns/1ps
module mcpbd_host_bench;
reg mclk_i = 0, rst_b_i = 0, cmd_valid_i = 0, ram_sleep_i = 0, boot_guard_i = 0;
reg flash_one_reset_req_i = 0, flash_two_reset_req_i = 0;
reg flash_one_unprotect_i = 0, flash_two_unprotect_i = 0;
reg [1:0] cmd_op_i = 0, cmd_target_i = 0, cmd_be_i = 0;
reg [21:0] cmd_addr_i = 0;
reg [15:0] cmd_wdata_i = 0;
wire [15:0] dq_i, dq_o, rd_data_o;
wire [21:0] addr_o;
wire [1:0] flash_busy_o;
wire flash_one_ready_i, flash_two_ready_i, cmd_ready_o, cmd_err_o, rd_valid_o;
wire ram_asleep_o, flash_one_select_n_o, flash_two_select_n_o, ram_select_n_o;
wire ram_awake_o, oe_n_o, we_n_o, low_byte_select_n_o, high_byte_select_n_o;
wire sleep_program_n_o, dq_oe_n_o, flash_one_reset_n_o, flash_two_reset_n_o;
wire boot_guard_boost_o, flash_one_high_voltage_level_o, flash_two_high_voltage_level_o;
integer num_errors = 0, check_count = 0, seed = 32'h298FDA62, i;
reg e;
reg [31:0] r;
reg [15:0] q, ram_exp [0:15];
mcpbd_host dut_u (.*);
mcpbd_device dev_u (.*);
always #12.5 mclk_i = ~mclk_i;
function [15:0] lanes(input [15:0] old, input [15:0] wd, input [1:0] be);
	lanes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
endfunction
task conclude;
begin
	if (num_errors == 0 && check_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
end
endtask
task check(input [15:0] got, input [15:0] exp);
begin
	check_count = check_count + 1;
	if (got !== exp)
	begin
		num_errors = num_errors + 1;
		$display("mismatch at %0t: %h not %h", $time, got, exp);
	end
end
endtask
task cmd(input [1:0] op, input [1:0] tg, input [21:0] a, input [15:0] wd, input [1:0] be);
begin
	e = 1'b0;
	q = 16'hXXXX;
	repeat (20)
		if (cmd_ready_o !== 1'b1)
			@(negedge mclk_i);
	cmd_op_i = op;
	cmd_target_i = tg;
	cmd_addr_i = a;
	cmd_wdata_i = wd;
	cmd_be_i = be;
	cmd_valid_i = 1'b1;
	@(negedge mclk_i);
	cmd_valid_i = 1'b0;
	// A refusal pulses only in the cycle right after the taking edge.
	if (cmd_err_o === 1'b1)
		e = 1'b1;
	repeat (9)
	begin
		@(posedge mclk_i);
		#1;
		if (cmd_err_o === 1'b1)
			e = 1'b1;
		if (rd_valid_o === 1'b1)
			q = rd_data_o;
	end
	@(negedge mclk_i);
end
endtask
initial
begin
	#200000;
	num_errors = num_errors + 1;
	conclude;
end
initial
begin
	repeat (4) @(negedge mclk_i);
	rst_b_i = 1;
	cmd(2'h2, 2'h0, 22'h000001, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0000);
	cmd(2'h2, 2'h0, 22'h000001, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0001);
	for (i = 0; i < 16; i = i + 1)
	begin
		cmd(2'h1, 2'h2, i[21:0], 16'hFFFF, 2'h3);
		ram_exp[i] = 16'hFFFF;
	end
	for (i = 0; i < 40; i = i + 1)
	begin
		r = $random(seed);
		cmd(2'h1, 2'h2, {18'h0, r[3:0]}, r[31:16], r[5:4]);
		check({15'h0, e}, {15'h0, r[5:4] == 2'h0});
		if (r[5:4] != 2'h0)
			ram_exp[r[3:0]] = lanes(ram_exp[r[3:0]], r[31:16], r[5:4]);
		cmd(2'h0, 2'h2, {18'h0, r[9:6]}, 16'h0000, r[11:10]);
		check(q, ram_exp[r[9:6]]);
	end
	ram_sleep_i = 1;
	repeat (4) @(negedge mclk_i);
	check({15'h0, ram_asleep_o}, 16'h0001);
	cmd(2'h0, 2'h2, 22'h000003, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0001);
	ram_sleep_i = 0;
	repeat (4) @(negedge mclk_i);
	cmd(2'h0, 2'h2, 22'h000003, 16'h0000, 2'h0);
	check(q, ram_exp[3]);
	cmd(2'h1, 2'h0, 22'h000000, 16'hA5A5, 2'h3);
	boot_guard_i = 1;
	cmd(2'h1, 2'h0, 22'h000000, 16'h5A5A, 2'h3);
	cmd(2'h0, 2'h0, 22'h000000, 16'h0000, 2'h0);
	check(q, 16'hA5A5);
	cmd(2'h1, 2'h0, 22'h004001, 16'h1234, 2'h3);
	flash_two_reset_req_i = 1;
	repeat (6) @(negedge mclk_i);
	check({14'h0, flash_busy_o}, 16'h0002);
	cmd(2'h0, 2'h1, 22'h000000, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0001);
	cmd(2'h0, 2'h0, 22'h004001, 16'h0000, 2'h0);
	check(q, 16'h1234);
	cmd(2'h0, 2'h2, 22'h000003, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0001);
	cmd(2'h3, 2'h0, 22'h000000, 16'h0000, 2'h3);
	check({15'h0, e}, 16'h0001);
	cmd(2'h0, 2'h3, 22'h000000, 16'h0000, 2'h0);
	check({15'h0, e}, 16'h0001);
	flash_one_unprotect_i = 1;
	repeat (2) @(negedge mclk_i);
	check({14'h0, flash_two_high_voltage_level_o,
		flash_one_high_voltage_level_o}, 16'h0001);
	conclude;
end
endmodule
